// ### rtl/sgp_regs.svh
// Purpose: offsets, keys and reset values of the port config block
// Assumes: 16-bit host i/o addresses, 8-bit data
// Notes: definitions only
`ifndef SGP_REGS_SVH
`define SGP_REGS_SVH
`define SGP_INDEX_PORT 16'h002E
`define SGP_DATA_PORT 16'h002F
`define SGP_KEY_ENTER 8'h87
`define SGP_KEY_EXIT 8'hAA
`define SGP_IDX_DEV_SELECT 8'h07
`define SGP_IDX_PORT_FUNCTION_ENABLE 8'h30
`define SGP_IDX_LINE_DIRECTION 8'hE0
`define SGP_IDX_LINE_DATA 8'hE1
`define SGP_IDX_LINE_POLARITY_INVERT 8'hE2
`define SGP_DEV_LINE_REGS 8'h07
`define SGP_DEV_PORT_ENABLE 8'h09
`define SGP_ENABLE_BIT 7
`define SGP_RST_DIRECTION 8'hFF
`define SGP_RST_DATA 8'h00
`define SGP_RST_INVERT 8'h00
`define SGP_RST_ENABLE 8'h00
`define SGP_RST_INDEX 8'h00
`define SGP_RST_DEVICE 8'h00
`define SGP_IDLE_READ 8'hFF
`endif

// ### rtl/sgp_pkg.sv
// Purpose: shared types of the port config block
// Assumes: nothing beyond the header
// Notes: unlock states are one-hot
package sgp_pkg;
  typedef logic [7:0] sgp_byte_t;
  typedef enum logic [2:0] {
    SGP_LOCKED = 3'b001,
    SGP_HALF = 3'b010,
    SGP_OPEN = 3'b100
  } sgp_mode_t;
endpackage

// ### rtl/sgp_line_if.sv
// Purpose: carries line settings and sampled levels between modules
// Assumes: one clock
// Notes: ctrl drives settings, bank returns levels
`timescale 1ns/1ns
interface sgp_line_if;
  import sgp_pkg::*;
  sgp_byte_t direction;
  sgp_byte_t dataOut;
  sgp_byte_t invert;
  logic portEnable;
  sgp_byte_t levelIn;
  modport ctrl (output direction, dataOut, invert, portEnable,
                input levelIn);
  modport bank (input direction, dataOut, invert, portEnable,
                output levelIn);
endinterface

// ### rtl/sgp_line_bank.sv
// Purpose: eight pin drivers with input synchroniser and inversion
// Assumes: pins are asynchronous to clk
// Notes: lines float while the port function is disabled
`timescale 1ns/1ns
module sgp_line_bank
  import sgp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire sgp_pkg::sgp_byte_t pinIn, // pin levels
  output logic [7:0] pinOut, // pin drive levels
  output logic [7:0] pinOe, // high drives the pin
  sgp_line_if.bank lines // settings and levels
);
  import sgp_pkg::*;

  sgp_byte_t syncA_r;
  sgp_byte_t syncB_r;
  sgp_byte_t outLevel_r;
  sgp_byte_t outEn_r;
  wire sgp_byte_t outLevel_nxt = lines.dataOut ^ lines.invert;
  wire sgp_byte_t outEn_nxt = lines.portEnable ? ~lines.direction : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncA_r <= 8'h00;
      syncB_r <= 8'h00;
      outLevel_r <= 8'h00;
      outEn_r <= 8'h00;
    end else begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
      outLevel_r <= outLevel_nxt;
      outEn_r <= outEn_nxt;
    end
  end

  assign pinOut = outLevel_r;
  assign pinOe = outEn_r;
  assign lines.levelIn = syncB_r ^ lines.invert;
endmodule

// ### rtl/sgp_config_port.sv
// Purpose: index/data config port with eight-line general i/o port
// Assumes: host i/o cycles arrive as one-cycle strobes on clk
// Notes: read data is registered, valid one cycle after the strobe
`timescale 1ns/1ns
`include "sgp_regs.svh"
module sgp_config_port
  import sgp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic [15:0] ioAddr, // host i/o address
  input wire logic ioWrStb, // host write strobe
  input wire logic ioRdStb, // host read strobe
  input wire sgp_pkg::sgp_byte_t ioWrData, // host write data
  output sgp_pkg::sgp_byte_t ioRdData, // host read data
  output logic ioRdValid, // read data valid pulse
  output logic cfgOpen, // config mode active
  input wire sgp_pkg::sgp_byte_t pinIn, // pin levels
  output logic [7:0] pinOut, // pin drive levels
  output logic [7:0] pinOe // high drives the pin
);
  import sgp_pkg::*;

  sgp_mode_t mode_r;
  sgp_mode_t mode_nxt;
  sgp_byte_t index_r;
  sgp_byte_t device_r;
  sgp_byte_t enable_r;
  sgp_byte_t direction_r;
  sgp_byte_t data_r;
  sgp_byte_t invert_r;
  sgp_byte_t rdData_r;
  logic rdValid_r;

  sgp_line_if lines ();

  // decoding of the host cycle
  wire hitIndex = (ioAddr == `SGP_INDEX_PORT);
  wire hitData = (ioAddr == `SGP_DATA_PORT);
  wire wrIndex = ioWrStb && hitIndex;
  wire isOpen = (mode_r == SGP_OPEN);
  wire wrData = ioWrStb && hitData && isOpen;
  wire rdData = ioRdStb && hitData && isOpen;
  wire devLines = (device_r == `SGP_DEV_LINE_REGS);
  wire devEnable = (device_r == `SGP_DEV_PORT_ENABLE);
  wire selDevice = (index_r == `SGP_IDX_DEV_SELECT);
  wire selEnable = devEnable &&
                   (index_r == `SGP_IDX_PORT_FUNCTION_ENABLE);
  wire selDir = devLines && (index_r == `SGP_IDX_LINE_DIRECTION);
  wire selData = devLines && (index_r == `SGP_IDX_LINE_DATA);
  wire selInv = devLines && (index_r == `SGP_IDX_LINE_POLARITY_INVERT);

  // input lines keep their stored bit, outputs take the write
  function automatic sgp_byte_t mergeData(input sgp_byte_t wr,
                                          input sgp_byte_t old,
                                          input sgp_byte_t dir);
    mergeData = (wr & ~dir) | (old & dir);
  endfunction

  // readback of the line data: stored for outputs, pin for inputs
  wire sgp_byte_t dataView = (data_r & ~direction_r) |
                             (lines.levelIn & direction_r);

  wire sgp_byte_t regView =
    selDevice ? device_r :
    selEnable ? enable_r :
    selDir ? direction_r :
    selData ? dataView :
    selInv ? invert_r : `SGP_IDLE_READ;

  wire sgp_byte_t rdNxt = hitIndex ? index_r : regView;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      SGP_LOCKED: begin
        if (wrIndex && ioWrData == `SGP_KEY_ENTER) begin
          mode_nxt = SGP_HALF;
        end
      end
      SGP_HALF: begin
        if (ioWrStb) begin
          if (wrIndex && ioWrData == `SGP_KEY_ENTER) begin
            mode_nxt = SGP_OPEN;
          end else begin
            mode_nxt = SGP_LOCKED;
          end
        end
      end
      SGP_OPEN: begin
        if (wrIndex && ioWrData == `SGP_KEY_EXIT) begin
          mode_nxt = SGP_LOCKED;
        end
      end
      default: mode_nxt = SGP_LOCKED;
    endcase
  end

  // write qualifiers per register
  wire idxWr = wrIndex && isOpen && (ioWrData != `SGP_KEY_EXIT);
  wire devWr = wrData && selDevice;
  wire enaWr = wrData && selEnable;
  wire dirWr = wrData && selDir;
  wire datWr = wrData && selData;
  wire invWr = wrData && selInv;
  wire rdHit = ioRdStb && (hitIndex || hitData);
  // locked reads answer the idle value
  wire rdOpen = rdData || (ioRdStb && hitIndex && isOpen);

  // exit key never lands in the index
  wire sgp_byte_t index_nxt = idxWr ? ioWrData : index_r;
  wire sgp_byte_t device_nxt = devWr ? ioWrData : device_r;
  wire sgp_byte_t enable_nxt = enaWr ? ioWrData : enable_r;
  wire sgp_byte_t direction_nxt =
    dirWr ? ioWrData : direction_r;
  wire sgp_byte_t data_nxt =
    datWr ? mergeData(ioWrData, data_r, direction_r) : data_r;
  wire sgp_byte_t invert_nxt = invWr ? ioWrData : invert_r;
  wire sgp_byte_t rdData_nxt =
    rdHit ? (rdOpen ? rdNxt : `SGP_IDLE_READ) : rdData_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= SGP_LOCKED;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      index_r <= `SGP_RST_INDEX;
    end else begin
      index_r <= index_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_r <= `SGP_RST_DEVICE;
    end else begin
      device_r <= device_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_r <= `SGP_RST_ENABLE;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      direction_r <= `SGP_RST_DIRECTION;
    end else begin
      direction_r <= direction_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_r <= `SGP_RST_DATA;
    end else begin
      data_r <= data_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      invert_r <= `SGP_RST_INVERT;
    end else begin
      invert_r <= invert_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_r <= `SGP_IDLE_READ;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= rdHit;
    end
  end

  assign lines.direction = direction_r;
  assign lines.dataOut = data_r;
  assign lines.invert = invert_r;
  assign lines.portEnable = enable_r[`SGP_ENABLE_BIT];

  sgp_line_bank bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .lines(lines)
  );

  assign ioRdData = rdData_r;
  assign ioRdValid = rdValid_r;
  assign cfgOpen = isOpen;
endmodule

// ### dv/sgp_pin_model.sv
// Purpose: far-side pin levels for the config port
// Assumes: no pull on the lines
// Notes: far side drives only lines the device leaves
`timescale 1ns/1ns
module sgp_pin_model (
  input wire logic [7:0] pinOut, // device drive levels
  input wire logic [7:0] pinOe, // device drive enables
  input wire logic [7:0] extLevel, // far-side levels
  output logic [7:0] pinIn // resolved pin levels
);
  // per line, the device wins while it drives
  assign pinIn = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule

// ### dv/sgp_config_port_props.sv
// Purpose: port checks for the config port
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ns
module sgp_config_port_props
  import sgp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic [15:0] ioAddr, // address
  input wire logic ioWrStb, // write strobe
  input wire logic ioRdStb, // read strobe
  input wire sgp_pkg::sgp_byte_t ioWrData, // write data
  input wire sgp_pkg::sgp_byte_t ioRdData, // read data
  input wire logic ioRdValid, // read valid
  input wire logic cfgOpen, // config open
  input wire sgp_pkg::sgp_byte_t pinIn, // pins
  input wire logic [7:0] pinOut, // drive
  input wire logic [7:0] pinOe // enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire hit = ioAddr == 16'h002E || ioAddr == 16'h002F;
  wire idxW = ioWrStb && ioAddr == 16'h002E;
  wire key = idxW && ioWrData == 8'h87;
  rd_valid_a: assert property (ioRdStb && hit |=> ioRdValid)
    else $error("read not answered");
  no_valid_a: assert property (!(ioRdStb && hit) |=> !ioRdValid)
    else $error("spurious read valid");
  locked_read_a: assert property (!cfgOpen && ioRdStb && hit |=>
    ioRdData == 8'hFF) else $error("locked read not FF");
  unlock_key_a: assert property (!cfgOpen && key && $past(key) |=>
    cfgOpen) else $error("double key did not unlock");
  exit_key_a: assert property (cfgOpen && idxW && ioWrData == 8'hAA
    |=> !cfgOpen) else $error("exit key did not lock");
  pins_hold_a: assert property (!ioWrStb [*3] |-> $stable(pinOut) &&
    $stable(pinOe)) else $error("pins moved without write");
  rd_hold_a: assert property (!(ioRdStb && hit) |=> $stable(ioRdData))
    else $error("read data moved");
  other_addr_a: assert property (ioWrStb && !hit |=> $stable(cfgOpen))
    else $error("foreign write changed mode");
  cover property ($rose(cfgOpen));
  cover property ($fell(cfgOpen));
  cover property (cfgOpen && ioRdStb && ioAddr == 16'h002F);
endmodule
bind sgp_config_port sgp_config_port_props chk (.clk(clk),
  .sys_rst(sys_rst), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
  .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData),
  .ioRdValid(ioRdValid), .cfgOpen(cfgOpen), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe));

// ### dv/test_sgp_config_port.sv
// Purpose: scenarios for the config port
// Assumes: strobes driven 1 ns after the edge
// Notes: pins resolved by the pin model
`timescale 1ns/1ns
`include "sgp_regs.svh"
module test_sgp_config_port;
  import sgp_pkg::*;
  logic clk = 0, sysRst = 1, ioWrStb = 0, ioRdStb = 0, ioRdValid, cfgOpen;
  logic [15:0] ioAddr = 16'h0000;
  sgp_byte_t ioWrData = 8'h00, ioRdData, pinIn, ext = 8'h00;
  logic [7:0] pinOut, pinOe;
  int badCount = 0, checksDone = 0;
  always #25 clk = ~clk;
  sgp_config_port uut (.clk(clk), .sys_rst(sysRst), .ioAddr(ioAddr),
    .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .ioRdValid(ioRdValid), .cfgOpen(cfgOpen),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  sgp_pin_model pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext),
    .pinIn(pinIn));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input sgp_byte_t d, input int n);
    ioAddr = a;
    ioWrData = d;
    ioWrStb = 1;
    repeat (n) @(posedge clk);
    #1 ioWrStb = 0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input sgp_byte_t exp);
    ioAddr = a;
    ioRdStb = 1;
    @(posedge clk);
    #1 ioRdStb = 0;
    chk({7'h00, ioRdValid}, 8'h01);
    chk(ioRdData, exp);
    @(posedge clk);
    #1;
  endtask
  task automatic cfg(input sgp_byte_t i, input sgp_byte_t v);
    wr(`SGP_INDEX_PORT, i, 1);
    wr(`SGP_DATA_PORT, v, 1);
    @(posedge clk);
    #1;
  endtask
  task automatic cget(input sgp_byte_t i, input sgp_byte_t exp);
    wr(`SGP_INDEX_PORT, i, 1);
    rd(`SGP_DATA_PORT, exp);
  endtask
  task automatic t_unlock;
    rd(`SGP_DATA_PORT, 8'hFF);
    wr(`SGP_INDEX_PORT, 8'h87, 1);
    wr(`SGP_DATA_PORT, 8'h11, 1);
    wr(`SGP_INDEX_PORT, 8'h87, 1);
    chk({7'h00, cfgOpen}, 8'h00);
    wr(16'h002D, 8'h87, 2);
    wr(`SGP_INDEX_PORT, 8'h87, 2);
    chk({7'h00, cfgOpen}, 8'h01);
  endtask
  task automatic t_output;
    cfg(8'h07, 8'h09);
    cfg(8'h30, 8'h80);
    cget(8'h30, 8'h80);
    cget(8'hE0, 8'hFF);
    cfg(8'h07, 8'h07);
    cfg(8'hE0, 8'h00);
    chk(pinOe, 8'hFF);
    cfg(8'hE1, 8'h55);
    chk(pinOut, 8'h55);
    cget(8'hE1, 8'h55);
    rd(`SGP_INDEX_PORT, 8'hE1);
    cfg(8'hE2, 8'hA5);
    chk(pinOut, 8'hF0);
  endtask
  task automatic t_input;
    ext = 8'h3C;
    cfg(8'hE0, 8'hF0);
    cfg(8'hE1, 8'hFF);
    chk(pinOe, 8'h0F);
    chk(pinOut & 8'h0F, 8'h0A);
    cget(8'hE1, 8'h9F);
    cfg(8'hE2, 8'h00);
    cget(8'hE1, 8'h3F);
  endtask
  task automatic t_lock;
    wr(`SGP_INDEX_PORT, 8'hAA, 1);
    chk({7'h00, cfgOpen}, 8'h00);
    wr(`SGP_DATA_PORT, 8'h00, 1);
    rd(`SGP_DATA_PORT, 8'hFF);
    rd(`SGP_INDEX_PORT, 8'hFF);
    chk(pinOe, 8'h0F);
    chk(pinOut, 8'h5F);
  endtask
  task automatic completeRun;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 sysRst = 0;
    chk(pinOe, 8'h00);
    t_unlock();
    t_output();
    t_input();
    t_lock();
    completeRun();
  end
endmodule
